// [logic/fpro_pkg.sv]
/*
 * Shared constants for the flash protect and RAM overlay block:
 * register offsets and fields, the erase block map, the RAM window
 * and the operating mode type.
 * Assumes a 24-bit CPU address space and an APB register bus.
 */
package fpro_pkg;

    localparam int FPRO_AW = 24;
    localparam int FPRO_NBLK = 14;

    // register byte offsets on the APB bus
    localparam logic [11:0] FPRO_OFS_CTRL = 12'h000;
    localparam logic [11:0] FPRO_OFS_STAT = 12'h004;

    // flash system control fields
    localparam logic [7:0] FPRO_CTRL_RESET = 8'h00;
    localparam logic [7:0] FPRO_CTRL_WMASK = 8'h0F;
    localparam int FPRO_CTRL_EMUL_BIT = 3;
    localparam int FPRO_CTRL_AREA_LSB = 0;
    localparam int FPRO_CTRL_AREA_W = 3;

    // status register fields
    localparam int FPRO_STAT_MODE_LSB = 0;
    localparam int FPRO_STAT_PE_OK_BIT = 2;
    localparam int FPRO_STAT_DENIED_BIT = 3;
    localparam int FPRO_STAT_ROM_BIT = 4;

    // erase block map
    localparam logic [FPRO_AW-1:0] FPRO_SMALL_END = 24'h008000;
    localparam logic [FPRO_AW-1:0] FPRO_MID_END = 24'h010000;
    localparam logic [FPRO_AW-1:0] FPRO_FLASH_END = 24'h060000;
    localparam logic [FPRO_AW-1:0] FPRO_SMALL_SIZE = 24'h001000;
    localparam logic [FPRO_AW-1:0] FPRO_LARGE_SIZE = 24'h010000;
    localparam int FPRO_NSMALL = 8;

    // RAM emulation window
    localparam logic [FPRO_AW-1:0] FPRO_RAMWIN_BASE = 24'hFFDC00;
    localparam logic [FPRO_AW-1:0] FPRO_RAMWIN_LAST = 24'hFFEBFF;
    localparam int FPRO_WIN_AW = 12;

    // strap codes of the mode pins
    localparam logic [2:0] FPRO_PINS_PROM = 3'h0;
    localparam logic [2:0] FPRO_PINS_BOOT = 3'h1;

    typedef enum logic [1:0] {
        FPRO_MODE_USER,
        FPRO_MODE_USER_PROG,
        FPRO_MODE_BOOT,
        FPRO_MODE_PROM
    } fpro_mode_t;

    // first address of erase block i
    function automatic logic [FPRO_AW-1:0] fpro_blk_base(input int i);
        logic [FPRO_AW-1:0] base;
        base = FPRO_SMALL_SIZE * i[FPRO_AW-1:0];
        if (i == FPRO_NSMALL) begin
            base = FPRO_SMALL_END;
        end else if (i > FPRO_NSMALL) begin
            base = FPRO_LARGE_SIZE * (i[FPRO_AW-1:0] - 24'h000008);
        end
        return base;
    endfunction : fpro_blk_base

endpackage : fpro_pkg

// [logic/fpro_map.sv]
/*
 * Erase block decoder: tells whether an address falls in flash and
 * which erase block holds it.
 * Assumes a 24-bit address; purely combinational.
 */
`timescale 1ns/1ps
module fpro_map (
    input wire logic [fpro_pkg::FPRO_AW-1:0] i_addr,
    output logic o_in_flash,
    output logic [3:0] o_block
);
    import fpro_pkg::*;

    logic [FPRO_NBLK-1:0] hit;

    // one comparator pair per erase block
    genvar g;
    generate
        for (g = 0; g < FPRO_NBLK; g++) begin : g_blk
            localparam logic [FPRO_AW-1:0] LO = fpro_blk_base(g);
            localparam logic [FPRO_AW-1:0] HI = (g == FPRO_NBLK - 1) ? FPRO_FLASH_END : fpro_blk_base(g + 1);
            assign hit[g] = (i_addr >= LO) && (i_addr < HI);
        end
    endgenerate

    // blocks never overlap, so a priority encode is a plain index
    always_comb begin
        o_in_flash = |hit;
        o_block = 4'h0;
        for (int i = 0; i < FPRO_NBLK; i++) begin
            if (hit[i]) begin
                o_block = i[3:0];
            end
        end
    end

endmodule : fpro_map

// [logic/fpro_top.sv]
/*
 * Flash protect and RAM overlay controller: holds the flash system
 * control register, latches the flash operating mode at the first edge after reset release,
 * grants or refuses program/erase and redirects CPU accesses of the
 * overlaid erase block into the 4 KB RAM window.
 * Assumes an APB master, mode and write permit pins that are steady
 * around reset release, and a CPU access port that is synchronous
 * to i_mclk.
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module fpro_top #(
    parameter bit MASK_ROM = 1'b0,
    parameter logic [7:0] ROM_READ_VALUE = 8'h5A // arbitrary value
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hw_standby,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // strap pins
    input wire logic [2:0] i_mode_pins,
    input wire logic i_flash_write_permit_pin,
    // CPU access port
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic i_acc_pe,
    input wire logic [fpro_pkg::FPRO_AW-1:0] i_acc_addr,
    // routed access
    output logic o_rt_valid,
    output logic o_rt_ram,
    output logic o_rt_flash,
    output logic o_rt_write,
    output logic [fpro_pkg::FPRO_AW-1:0] o_rt_addr,
    output logic [3:0] o_rt_block,
    output logic o_rt_pe_grant,
    output logic o_rt_pe_denied,
    // live state
    output logic o_emulation_select,
    output logic [1:0] o_flash_mode
);
    import fpro_pkg::*;

    // flash system control register
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;

    // strap capture
    logic strap_done_reg;
    logic strap_done_next;
    fpro_mode_t mode_reg;
    fpro_mode_t mode_next;

    // sticky refusal flag
    logic denied_reg;
    logic denied_next;

    // routed access pipeline
    logic rt_valid_reg;
    logic rt_valid_next;
    logic rt_ram_reg;
    logic rt_ram_next;
    logic rt_flash_reg;
    logic rt_flash_next;
    logic rt_write_reg;
    logic rt_write_next;
    logic [FPRO_AW-1:0] rt_addr_reg;
    logic [FPRO_AW-1:0] rt_addr_next;
    logic [3:0] rt_block_reg;
    logic [3:0] rt_block_next;
    logic rt_grant_reg;
    logic rt_grant_next;
    logic rt_denied_reg;
    logic rt_denied_next;

    // APB read data
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // decode helpers
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic hit_ctrl;
    logic hit_stat;
    logic emul_sel;
    logic [FPRO_CTRL_AREA_W-1:0] area;
    logic in_flash;
    logic [3:0] block;
    logic mode_pe_ok;
    logic overlaid;
    logic in_ramwin;
    logic pe_try;
    logic pe_grant;
    logic pe_refuse;
    logic [7:0] stat_val;

    fpro_map u_map (
        .i_addr(i_acc_addr),
        .o_in_flash(in_flash),
        .o_block(block)
    );

    // bus decode: zero wait states, so every access phase completes
    assign apb_access = i_psel && i_penable;
    assign apb_wr = apb_access && i_pwrite;
    assign apb_rd = apb_access && !i_pwrite;
    assign hit_ctrl = (i_paddr == FPRO_OFS_CTRL);
    assign hit_stat = (i_paddr == FPRO_OFS_STAT);

    // control fields
    assign emul_sel = ctrl_reg[FPRO_CTRL_EMUL_BIT];
    assign area = ctrl_reg[FPRO_CTRL_AREA_LSB +: FPRO_CTRL_AREA_W];

    // the latched mode's share of the program and erase permission
    always_comb begin
        case (mode_reg)
            FPRO_MODE_USER: mode_pe_ok = 1'b0;
            FPRO_MODE_USER_PROG: mode_pe_ok = 1'b1;
            FPRO_MODE_BOOT: mode_pe_ok = 1'b1;
            FPRO_MODE_PROM: mode_pe_ok = 1'b1;
            default: mode_pe_ok = 1'b0;
        endcase
    end

    // overlay hit: only when emulating and the block matches the area
    assign overlaid = emul_sel && in_flash && (block == {1'b0, area});
    assign in_ramwin = (i_acc_addr >= FPRO_RAMWIN_BASE) && (i_acc_addr <= FPRO_RAMWIN_LAST);

    // emulation protects every block, whatever the mode allows
    assign pe_try = i_acc_valid && i_acc_pe;
    assign pe_grant = pe_try && in_flash && mode_pe_ok && !emul_sel;
    assign pe_refuse = pe_try && !pe_grant;

    // flash system control register next value
    always_comb begin
        ctrl_next = ctrl_reg;
        if (i_hw_standby) begin
            ctrl_next = FPRO_CTRL_RESET;
        end else if (apb_wr && hit_ctrl && !MASK_ROM) begin
            ctrl_next = i_pwdata[7:0] & FPRO_CTRL_WMASK;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= FPRO_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // mode is taken from the pins at the first edge after reset release
    always_comb begin
        strap_done_next = 1'b1;
        mode_next = mode_reg;
        if (!strap_done_reg) begin
            if (i_mode_pins == FPRO_PINS_PROM) begin
                mode_next = FPRO_MODE_PROM;
            end else if (!i_flash_write_permit_pin) begin
                mode_next = FPRO_MODE_USER;
            end else if (i_mode_pins == FPRO_PINS_BOOT) begin
                mode_next = FPRO_MODE_BOOT;
            end else begin
                mode_next = FPRO_MODE_USER_PROG;
            end
        end
    end

    // the pins are not looked at later, so a pin change needs a reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_done_reg <= 1'b0;
            mode_reg <= FPRO_MODE_USER;
        end else begin
            strap_done_reg <= strap_done_next;
            mode_reg <= mode_next;
        end
    end

    // sticky refusal flag: a new refusal wins over a clear in the same cycle
    always_comb begin
        denied_next = denied_reg;
        if (apb_wr && hit_stat && i_pwdata[FPRO_STAT_DENIED_BIT]) begin
            denied_next = 1'b0;
        end
        if (pe_refuse) begin
            denied_next = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            denied_reg <= 1'b0;
        end else begin
            denied_reg <= denied_next;
        end
    end

    // route each CPU access one cycle later
    always_comb begin
        rt_valid_next = i_acc_valid;
        rt_write_next = i_acc_write;
        rt_block_next = block;
        rt_grant_next = pe_grant;
        rt_denied_next = pe_refuse;
        rt_ram_next = 1'b0;
        rt_flash_next = 1'b0;
        rt_addr_next = i_acc_addr;
        if (i_acc_valid) begin
            if (overlaid && !i_acc_pe) begin
                rt_ram_next = 1'b1;
                // the window base is not 4 KB aligned, so the offset must be added, never or-ed
                rt_addr_next = FPRO_RAMWIN_BASE + {{(FPRO_AW - FPRO_WIN_AW){1'b0}}, i_acc_addr[FPRO_WIN_AW-1:0]};
            end else if (in_flash) begin
                rt_flash_next = !i_acc_pe || pe_grant;
            end else if (in_ramwin) begin
                rt_ram_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rt_valid_reg <= 1'b0;
            rt_ram_reg <= 1'b0;
            rt_flash_reg <= 1'b0;
            rt_write_reg <= 1'b0;
            rt_addr_reg <= '0;
            rt_block_reg <= 4'h0;
            rt_grant_reg <= 1'b0;
            rt_denied_reg <= 1'b0;
        end else begin
            rt_valid_reg <= rt_valid_next;
            rt_ram_reg <= rt_ram_next;
            rt_flash_reg <= rt_flash_next;
            rt_write_reg <= rt_write_next;
            rt_addr_reg <= rt_addr_next;
            rt_block_reg <= rt_block_next;
            rt_grant_reg <= rt_grant_next;
            rt_denied_reg <= rt_denied_next;
        end
    end

    // status view of the block
    always_comb begin
        stat_val = 8'h00;
        stat_val[FPRO_STAT_MODE_LSB +: 2] = mode_reg;
        stat_val[FPRO_STAT_PE_OK_BIT] = mode_pe_ok && !emul_sel;
        stat_val[FPRO_STAT_DENIED_BIT] = denied_reg;
        stat_val[FPRO_STAT_ROM_BIT] = MASK_ROM;
    end

    // read data is registered in the setup cycle so it is ready at access
    always_comb begin
        prdata_next = prdata_reg;
        if (i_psel && !i_penable && !i_pwrite) begin
            prdata_next = 32'h0000_0000;
            if (hit_ctrl) begin
                prdata_next[7:0] = MASK_ROM ? ROM_READ_VALUE : ctrl_reg;
            end else if (hit_stat) begin
                prdata_next[7:0] = stat_val;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    // unmapped offsets answer with an error and leave all state alone
    assign o_pready = 1'b1;
    assign o_pslverr = apb_access && !(hit_ctrl || hit_stat);
    assign o_prdata = apb_rd ? prdata_reg : 32'h0000_0000;

    assign o_rt_valid = rt_valid_reg;
    assign o_rt_ram = rt_ram_reg;
    assign o_rt_flash = rt_flash_reg;
    assign o_rt_write = rt_write_reg;
    assign o_rt_addr = rt_addr_reg;
    assign o_rt_block = rt_block_reg;
    assign o_rt_pe_grant = rt_grant_reg;
    assign o_rt_pe_denied = rt_denied_reg;
    assign o_emulation_select = emul_sel;
    assign o_flash_mode = mode_reg;

endmodule : fpro_top

// [dv/fpro_properties.sv]
/*
 * Checker for fpro_top: register, mode, grant and routing relations.
 * Assumes it is bound onto every fpro_top, flash or mask ROM build,
 * and is told which build it watches.
 */
`timescale 1ns/1ps
module fpro_properties
    import fpro_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hw_standby,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic i_acc_valid,
    input wire logic i_acc_pe,
    input wire logic [fpro_pkg::FPRO_AW-1:0] i_acc_addr,
    input wire logic o_rt_ram,
    input wire logic o_rt_flash,
    input wire logic [fpro_pkg::FPRO_AW-1:0] o_rt_addr,
    input wire logic [3:0] o_rt_block,
    input wire logic o_rt_pe_grant,
    input wire logic o_rt_pe_denied,
    input wire logic o_emulation_select,
    input wire logic [1:0] o_flash_mode
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic rd_ctrl;
    logic [1:0] mode_cnt_reg;
    logic [1:0] mode_cnt_next;

    // expected erase block, valid only below the end of flash
    function automatic logic [3:0] exp_blk(input logic [23:0] a);
        if (a < 24'h008000) return a[15:12];
        if (a < 24'h010000) return 4'h8;
        return 4'h8 + a[19:16];
    endfunction : exp_blk

    // read access phase of the control register
    // the mask ROM build reads back an arbitrary value, so only the flash build is held to it
    assign rd_ctrl = !MASK_ROM && i_psel && i_penable && !i_pwrite && i_paddr == FPRO_OFS_CTRL;

    // cycles since reset release, saturating; straps settle at the first edge
    always_comb begin
        mode_cnt_next = (mode_cnt_reg == 2'h2) ? 2'h2 : mode_cnt_reg + 2'h1;
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) mode_cnt_reg <= 2'h0;
        else mode_cnt_reg <= mode_cnt_next;
    end

    a_ctrl_upper_zero: assert property (rd_ctrl |-> o_prdata[31:4] == 28'h0000000)
        else $error("control upper bits not zero");
    a_ctrl_emul_bit: assert property (rd_ctrl |-> o_prdata[3] == o_emulation_select)
        else $error("control emulation bit mismatch");
    a_standby_clear: assert property (i_hw_standby |=> !o_emulation_select)
        else $error("standby did not clear control");
    a_user_denied: assert property (i_acc_valid && i_acc_pe && o_flash_mode == FPRO_MODE_USER
        |=> o_rt_pe_denied && !o_rt_flash) else $error("program in user mode passed");
    a_emul_protect: assert property (i_acc_valid && i_acc_pe && o_emulation_select
        |=> o_rt_pe_denied && !o_rt_pe_grant) else $error("program while emulating passed");
    a_grant_mode: assert property (o_rt_pe_grant |-> $past(o_flash_mode) != FPRO_MODE_USER)
        else $error("grant in user mode");
    a_window_ram: assert property (i_acc_valid && i_acc_addr inside {[FPRO_RAMWIN_BASE:FPRO_RAMWIN_LAST]}
        |=> o_rt_ram && o_rt_addr == $past(i_acc_addr)) else $error("window not routed to ram");
    a_block_map: assert property (i_acc_valid && i_acc_addr < FPRO_FLASH_END && !o_emulation_select
        |=> o_rt_block == exp_blk($past(i_acc_addr))) else $error("wrong erase block");
    a_mode_hold: assert property (mode_cnt_reg == 2'h2 |-> $stable(o_flash_mode))
        else $error("mode changed outside reset");
    a_rom_locked: assert property (MASK_ROM |-> !o_emulation_select)
        else $error("mask rom control changed");

    c_emul_access: cover property (i_acc_valid && o_emulation_select);
    c_grant: cover property (o_rt_pe_grant);
    c_standby: cover property (i_hw_standby);
endmodule : fpro_properties

bind fpro_top fpro_properties #(.MASK_ROM(MASK_ROM)) u_props (.*);

// [dv/fpro_tb.sv]
/*
 * Self-checking bench for fpro_top: APB register tasks, CPU access task,
 * strap mode table, erase map table and overlay sweep.
 * Assumes zero-wait APB answers; a mask ROM build shares the bus and pins.
 */
`timescale 1ns/1ps
module tb;
    import fpro_pkg::*;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_hw_standby = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic o_pready, o_pslverr, i_flash_write_permit_pin = 1'b0, i_acc_valid = 1'b0, i_acc_write = 1'b0;
    logic i_acc_pe = 1'b0, o_rt_valid, o_rt_ram, o_rt_flash, o_rt_write, o_rt_pe_grant, o_rt_pe_denied;
    logic [2:0] i_mode_pins = 3'h1;
    logic [23:0] i_acc_addr = 24'h0, o_rt_addr;
    logic o_emulation_select;
    logic [3:0] o_rt_block;
    logic [1:0] o_flash_mode;
    int fails = 0, num_checks = 0;
    logic [31:0] rom_prdata, rom_rd;
    logic rom_emul, perr;
    localparam logic [7:0] ROM_VAL = 8'hA5; // arbitrary read value of the mask ROM build
    // strap table: user, programmer, boot, user program
    localparam logic [2:0] PINS [4] = '{3'h1, 3'h0, 3'h1, 3'h2};
    localparam logic WPIN [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    localparam logic [1:0] MODES [4] = '{FPRO_MODE_USER, FPRO_MODE_PROM, FPRO_MODE_BOOT, FPRO_MODE_USER_PROG};
    // block boundaries, last entry just past flash
    localparam logic [23:0] MAP_A [7] = '{24'h000000, 24'h007FFF, 24'h008000, 24'h00FFFF, 24'h010000,
        24'h05FFFF, 24'h060000};
    localparam logic [3:0] MAP_B [7] = '{4'h0, 4'h7, 4'h8, 4'h8, 4'h9, 4'hD, 4'h0};

    fpro_top uut (.*);

    // mask ROM build on the same bus and pins: its control writes must be ignored
    fpro_top #(
        .MASK_ROM(1'b1),
        .ROM_READ_VALUE(ROM_VAL)
    ) uut_rom (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_hw_standby(i_hw_standby),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .o_prdata(rom_prdata),
        .o_pready(),
        .o_pslverr(),
        .i_mode_pins(i_mode_pins),
        .i_flash_write_permit_pin(i_flash_write_permit_pin),
        .i_acc_valid(i_acc_valid),
        .i_acc_write(i_acc_write),
        .i_acc_pe(i_acc_pe),
        .i_acc_addr(i_acc_addr),
        .o_rt_valid(),
        .o_rt_ram(),
        .o_rt_flash(),
        .o_rt_write(),
        .o_rt_addr(),
        .o_rt_block(),
        .o_rt_pe_grant(),
        .o_rt_pe_denied(),
        .o_emulation_select(rom_emul),
        .o_flash_mode()
    );

    // 200 MHz clock
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // one APB transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdat);
        int n = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rdat = o_prdata;
        rom_rd = rom_prdata;
        perr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            print_verdict();
        end
    endtask : apb

    // one CPU access; routing is settled just after the following edge
    task automatic acc(input logic [23:0] a, input logic pe);
        @(posedge i_mclk);
        i_acc_valid <= 1'b1;
        i_acc_addr <= a;
        i_acc_pe <= pe;
        i_acc_write <= pe;
        @(posedge i_mclk);
        i_acc_valid <= 1'b0;
        #1;
    endtask : acc

    // straps are held steady across the whole reset
    task automatic do_reset(input logic [2:0] p, input logic w);
        i_rst_n <= 1'b0;
        i_mode_pins <= p;
        i_flash_write_permit_pin <= w;
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
    endtask : do_reset

    initial begin
        do_reset(3'h1, 1'b0);
        apb(1'b0, FPRO_OFS_CTRL, 32'h0, rd);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b1, FPRO_OFS_CTRL, 32'hFFFFFFFF, rd);
        apb(1'b0, FPRO_OFS_CTRL, 32'h0, rd);
        chk("ctrl writable bits", 32'h0F, rd);
        chk("rom ctrl read", {24'h000000, ROM_VAL}, rom_rd);
        chk("rom ctrl write", 1'b0, rom_emul);
        chk("known offset", 1'b0, perr);
        // an unmapped offset answers with an error and zero data
        apb(1'b0, 12'h008, 32'h0, rd);
        chk("unmapped error", 1'b1, perr);
        chk("unmapped data", 32'h0, rd);
        @(posedge i_mclk);
        i_hw_standby <= 1'b1;
        @(posedge i_mclk);
        i_hw_standby <= 1'b0;
        apb(1'b0, FPRO_OFS_CTRL, 32'h0, rd);
        chk("ctrl after standby", 32'h0, rd);
        // control is left non-zero so that the first reset of the mode loop has something to clear
        apb(1'b1, FPRO_OFS_CTRL, 32'h0F, rd);
        for (int m = 0; m < 4; m++) begin
            do_reset(PINS[m], WPIN[m]);
            chk("emul after reset", 1'b0, o_emulation_select);
            chk("mode pin", MODES[m], o_flash_mode);
            apb(1'b0, FPRO_OFS_STAT, 32'h0, rd);
            chk("mode", MODES[m], rd[1:0]);
            chk("pe ok", m != 0, rd[FPRO_STAT_PE_OK_BIT]);
            acc(24'h010000, 1'b1);
            chk("pe grant", m != 0, o_rt_pe_grant);
            chk("pe to flash", m != 0, o_rt_flash);
            chk("rt write", 1'b1, o_rt_write);
            apb(1'b0, FPRO_OFS_STAT, 32'h0, rd);
            chk("denied flag", m == 0, rd[FPRO_STAT_DENIED_BIT]);
        end
        for (int i = 0; i < 7; i++) begin
            acc(MAP_A[i], 1'b0);
            chk("block", MAP_B[i], o_rt_block);
            chk("rt valid", 1'b1, o_rt_valid);
            chk("in flash", i != 6, o_rt_flash);
        end
        // every area code, plus a neighbouring block that must not go to RAM
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, FPRO_OFS_CTRL, 32'h8 | n, rd);
            acc(24'(n) * FPRO_SMALL_SIZE + 24'h000ABC, 1'b0);
            chk("overlay ram", 1'b1, o_rt_ram);
            chk("overlay addr", FPRO_RAMWIN_BASE + 24'h000ABC, o_rt_addr);
            chk("emul pin", 1'b1, o_emulation_select);
            acc(24'(n ^ 1) * FPRO_SMALL_SIZE, 1'b0);
            chk("other block", 1'b0, o_rt_ram);
        end
        acc(24'h020000, 1'b1);
        chk("emul pe denied", 1'b1, o_rt_pe_denied);
        apb(1'b0, FPRO_OFS_STAT, 32'h0, rd);
        chk("denied set", 1'b1, rd[FPRO_STAT_DENIED_BIT]);
        chk("pe ok emul", 1'b0, rd[FPRO_STAT_PE_OK_BIT]);
        apb(1'b1, FPRO_OFS_STAT, 32'h8, rd);
        apb(1'b0, FPRO_OFS_STAT, 32'h0, rd);
        chk("denied cleared", 1'b0, rd[FPRO_STAT_DENIED_BIT]);
        apb(1'b1, FPRO_OFS_CTRL, 32'h7, rd);
        acc(24'h007ABC, 1'b0);
        chk("no overlay", 1'b1, o_rt_flash);
        acc(24'hFFE000, 1'b0);
        chk("window ram", 1'b1, o_rt_ram);
        acc(24'h020000, 1'b1);
        chk("pe unprotected", 1'b1, o_rt_pe_grant);
        print_verdict();
    end
endmodule : tb
